/* pkg/mirror_pkg.sv */
// shared constants and types for the mirror block pulse controller
package mirror_pkg;

  // ==========================================================
  // array geometry
  localparam int NUM_BLOCKS     = 16;
  localparam int ROWS_PER_BLOCK = 48;
  localparam int ROW_WORDS      = 32;
  localparam int WORD_W         = 16;

  // ==========================================================
  // register offsets (byte addresses) and fields
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_SPORT   = 8'h08;
  localparam logic [7:0] OFF_LOADED  = 8'h0C;
  localparam int         CTRL_GROUP  = 0;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_REFUSED  = 1;
  localparam int         ST_SPBUSY   = 2;
  localparam int         ST_TYPE     = 4;
  localparam int         SP_BUSY     = 8;
  localparam logic [1:0] CTRL_RESET  = 2'h0;

  // arbitrary code of the array type that uses the short waveform
  localparam logic [3:0] ARRAY_TYPE_SHORT = 4'h1;

  // ==========================================================
  // timing
  localparam int CLK_NS       = 100;
  localparam int STROBE_NS    = 200;
  localparam int GAP_NS       = 1000;
  localparam int SCK_HALF_NS  = 400;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC      = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
  localparam int TYPE_WAIT    = 3;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    GROUP_SINGLE, GROUP_DUAL, GROUP_QUAD, GROUP_GLOBAL
  } group_t;
  typedef enum logic [1:0] {
    LEVEL_BIAS, LEVEL_OFFSET, LEVEL_RESET
  } level_t;
  typedef enum logic [1:0] {
    CMD_NONE, CMD_DIRECT, CMD_RELEASE, CMD_CLEAR
  } cmd_t;

  typedef struct packed {
    logic        strobe;
    group_t      count;
    level_t      level;
    logic [3:0]  addr;
  } driver_ctrl_t;

  typedef struct packed {
    logic        clk;
    logic        valid;
    logic [15:0] data;
  } in_bus_t;

  typedef struct packed {
    logic [15:0] data;
    logic        clk;
    logic        ctrl;
  } out_bus_t;

endpackage

/* logic/input_sync.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module input_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* logic/serial_port.sv */
// byte-wide full-duplex serial master toward the pulse driver
`timescale 1ns/1ps
module serial_port #(
  parameter int HALF = mirror_pkg::SCK_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso,
  output logic            sel_n,
  output logic            sck,
  output logic            mosi,
  output logic            busy,
  output logic [7:0]      rx_byte
);
  logic [7:0] shift;
  logic [4:0] edges;
  logic [7:0] div;
  wire        tick = busy && (div == 8'(HALF - 1));
  wire        done = tick && (edges == 5'd16);

  if (HALF < 1 || HALF > 255) begin : g_chk
    $error("serial half period out of range");
  end

  // ==========================================================
  // select and data phase; data changes on falling sck
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy  <= 1'b0;
      sel_n <= 1'b1;
      mosi  <= 1'b0;
      shift <= 8'h00;
    end else if (ce) begin
      if (!busy && start) begin
        busy  <= 1'b1;
        sel_n <= 1'b0;
        shift <= tx_byte;
        mosi  <= tx_byte[7];
      end else if (done) begin
        busy  <= 1'b0;
        sel_n <= 1'b1;
      end else if (tick && !sck) begin
        shift <= {shift[6:0], miso};  // sample on rising
      end else if (tick && sck) begin
        mosi  <= shift[7];
      end
    end
  end

  // ==========================================================
  // clock divider, edge counter and received byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck     <= 1'b0;
      edges   <= 5'd0;
      div     <= 8'h00;
      rx_byte <= 8'h00;
    end else if (ce) begin
      if (!busy) begin
        div   <= 8'h00;
        edges <= 5'd0;
      end else if (tick) begin
        div   <= 8'h00;
        edges <= edges + 5'd1;
        if (done) rx_byte <= shift;
        else sck <= ~sck;
      end else begin
        div <= div + 8'h01;
      end
    end
  end
endmodule

/* logic/mirror_reset_ctrl.sv */
// mirror array loader and block clocking pulse sequencer
`timescale 1ns/1ps
module mirror_reset_ctrl #(
  parameter int ROW_WORDS = mirror_pkg::ROW_WORDS
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire mirror_pkg::in_bus_t       bus_in_a,
  input  wire mirror_pkg::in_bus_t       bus_in_b,
  input  wire logic [3:0]                block_select,
  input  wire mirror_pkg::cmd_t          block_command_mode,
  input  wire logic [3:0]                array_type_id,
  input  wire logic                      serial_port_data_out,
  input  wire logic                      driver_irq,
  output mirror_pkg::out_bus_t           array_bus_a,
  output mirror_pkg::out_bus_t           array_bus_b,
  output mirror_pkg::driver_ctrl_t       driver_ctrl,
  output logic                           driver_port_select_n_a,
  output logic                           driver_port_select_n_b,
  output logic                           serial_port_clock,
  output logic                           serial_port_data_in,
  output logic                           reset_active
);
  typedef enum logic [1:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP
  } state_t;

  if (ROW_WORDS < 1 || ROW_WORDS > 255) begin : g_chk
    $error("ROW_WORDS out of range");
  end

  // ==========================================================
  // pin synchronisers
  logic [41:0]         sync_q;
  mirror_pkg::in_bus_t sa;
  mirror_pkg::in_bus_t sb;
  wire  [3:0]          type_pin = sync_q[5:2];
  wire                 miso_s   = sync_q[1];
  wire                 irq_s    = sync_q[0];
  assign sa = sync_q[41:24];
  assign sb = sync_q[23:6];

  input_sync #(.W(42)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({bus_in_a, bus_in_b, array_type_id,
            serial_port_data_out, driver_irq}),
    .q    (sync_q)
  );

  // ==========================================================
  // registers
  logic        prev_clk_a;
  logic        prev_clk_b;
  logic [7:0]  word_cnt;
  logic [5:0]  row_cnt;
  logic [15:0] loaded;
  logic [1:0]  group;
  logic        refused;
  logic [3:0]  array_type;
  logic [1:0]  type_wait;
  logic        type_done;
  logic [7:0]  tcnt;
  logic [1:0]  step;
  logic [15:0] cur_mask;
  logic [3:0]  cur_addr;
  logic [1:0]  cur_count;
  logic        cur_release;
  logic        sp_busy;
  logic [7:0]  sp_rx;
  logic        irq_seen;
  state_t      state;
  state_t      next_state;

  // ==========================================================
  // link edges: both edges carry a word (double rate)
  wire word_a = (sa.clk ^ prev_clk_a) && sa.valid;
  wire word_b = (sb.clk ^ prev_clk_b) && sb.valid;
  wire row_end = word_a && (word_cnt == 8'(ROW_WORDS - 1));
  wire blk_end = row_end &&
                 (row_cnt == 6'(mirror_pkg::ROWS_PER_BLOCK - 1));
  wire [15:0] set_mask = blk_end ? (16'h0001 << block_select)
                                 : 16'h0000;

  // ==========================================================
  // group decode from grouping mode and block select
  wire is_single = (group == 2'(mirror_pkg::GROUP_SINGLE));
  wire is_dual   = (group == 2'(mirror_pkg::GROUP_DUAL));
  wire is_quad   = (group == 2'(mirror_pkg::GROUP_QUAD));
  wire [3:0] grp_addr = is_single ? block_select :
                        is_dual   ? {block_select[3:1], 1'b0} :
                        is_quad   ? {block_select[3:2], 2'b00}:
                                    4'h0;
  wire [15:0] grp_mask = is_single ? (16'h0001 << grp_addr) :
                         is_dual   ? (16'h0003 << grp_addr) :
                         is_quad   ? (16'h000F << grp_addr) :
                                     16'hFFFF;
  wire all_loaded = ((loaded & grp_mask) == grp_mask);

  // ==========================================================
  // command decode; unloaded direct request is refused
  wire req = (state == ST_IDLE) && type_done &&
             (block_command_mode != mirror_pkg::CMD_NONE);
  wire is_direct = (block_command_mode == mirror_pkg::CMD_DIRECT);
  wire is_rel    = (block_command_mode == mirror_pkg::CMD_RELEASE);
  wire is_clear  = (block_command_mode == mirror_pkg::CMD_CLEAR);
  wire accept  = req && ((is_direct && all_loaded) || is_rel);
  wire refuse  = req && is_direct && !all_loaded;
  wire [15:0] clr_mask = (accept || (req && is_clear)) ? grp_mask
                                                      : 16'h0000;
  wire type_short = (array_type == mirror_pkg::ARRAY_TYPE_SHORT);

  // waveform length picked by array type and pulse kind
  wire [1:0] wave_len = (cur_release || type_short) ? 2'd2 : 2'd3;

  // level of each event of the waveform
  function automatic mirror_pkg::level_t wave_level(
    input logic [1:0] s, input logic rel, input logic shrt);
    if (rel)
      return (s == 2'd0) ? mirror_pkg::LEVEL_RESET
                         : mirror_pkg::LEVEL_OFFSET;
    else if (shrt)
      return (s == 2'd0) ? mirror_pkg::LEVEL_RESET
                         : mirror_pkg::LEVEL_BIAS;
    else
      return (s == 2'd0) ? mirror_pkg::LEVEL_OFFSET :
             (s == 2'd1) ? mirror_pkg::LEVEL_RESET
                         : mirror_pkg::LEVEL_BIAS;
  endfunction

  // ==========================================================
  // sequencer next state: setup, strobe, gap per event
  wire strobe_end = (tcnt == 8'(mirror_pkg::STROBE_CYC - 1));
  wire gap_end    = (tcnt == 8'(mirror_pkg::GAP_CYC - 1));
  wire last_step  = (step == wave_len - 2'd1);
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (accept) next_state = ST_SETUP;
      ST_SETUP:  next_state = ST_STROBE;
      ST_STROBE: if (strobe_end) next_state = ST_GAP;
      ST_GAP:    if (gap_end) begin
        next_state = last_step ? ST_IDLE : ST_SETUP;
      end
      default:   next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // apb decode; one wait state, registered answer
  wire apb_take = psel && penable && !pready;
  wire apb_wr   = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == mirror_pkg::OFF_CTRL);
  wire hit_stat = (paddr == mirror_pkg::OFF_STATUS);
  wire hit_sp   = (paddr == mirror_pkg::OFF_SPORT);
  wire hit_ld   = (paddr == mirror_pkg::OFF_LOADED);
  wire hit      = hit_ctrl || hit_stat || hit_sp || hit_ld;
  wire sp_start = apb_wr && hit_sp && !sp_busy;
  wire clr_ref  = apb_wr && hit_stat && pwdata[mirror_pkg::ST_REFUSED];
  wire [31:0] stat_word = {24'h0, array_type, irq_seen, sp_busy,
                           refused, reset_active};
  wire [31:0] rdata = hit_ctrl ? {30'h0, group} :
                      hit_stat ? stat_word :
                      hit_sp   ? {23'h0, sp_busy, sp_rx} :
                      hit_ld   ? {16'h0, loaded} : 32'h0;

  // bus answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apb_take;
      pslverr <= apb_take && !hit;
      prdata  <= (apb_take && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // control and sticky status; refusal set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      group    <= mirror_pkg::CTRL_RESET;
      refused  <= 1'b0;
      irq_seen <= 1'b0;
    end else if (ce) begin
      if (apb_wr && hit_ctrl) group <= pwdata[1:0];
      refused  <= refuse || (refused && !clr_ref);
      irq_seen <= irq_s || (irq_seen && !clr_ref);
    end
  end

  // ==========================================================
  // array type caught after reset release once sync settles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      type_wait  <= 2'd0;
      type_done  <= 1'b0;
      array_type <= 4'h0;
    end else if (ce && !type_done) begin
      type_wait <= type_wait + 2'd1;
      if (type_wait == 2'(mirror_pkg::TYPE_WAIT - 1)) begin
        type_done  <= 1'b1;
        array_type <= type_pin;
      end
    end
  end

  // ==========================================================
  // load tracking: words form rows, rows form blocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_clk_a <= 1'b0;
      prev_clk_b <= 1'b0;
      word_cnt   <= 8'h00;
      row_cnt    <= 6'd0;
      loaded     <= 16'h0000;
    end else if (ce) begin
      prev_clk_a <= sa.clk;
      prev_clk_b <= sb.clk;
      if (word_a) word_cnt <= row_end ? 8'h00 : word_cnt + 8'h01;
      if (row_end) row_cnt <= blk_end ? 6'd0 : row_cnt + 6'd1;
      // a block finishing as its group is pulsed stays loaded
      loaded <= (loaded & ~clr_mask) | set_mask;
    end
  end

  // ==========================================================
  // forwarded double-rate output buses, data bits unchanged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      array_bus_a <= '0;
      array_bus_b <= '0;
    end else if (ce) begin
      if (word_a) begin
        array_bus_a.data <= sa.data;
        array_bus_a.clk  <= ~array_bus_a.clk;
        array_bus_a.ctrl <= (word_cnt == 8'h00);
      end
      if (word_b) begin
        array_bus_b.data <= sb.data;
        array_bus_b.clk  <= ~array_bus_b.clk;
        array_bus_b.ctrl <= (word_cnt == 8'h00);
      end
    end
  end

  // ==========================================================
  // sequencer state, event counter and captured group
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      tcnt        <= 8'h00;
      step        <= 2'd0;
      cur_mask    <= 16'h0000;
      cur_addr    <= 4'h0;
      cur_count   <= 2'd0;
      cur_release <= 1'b0;
      reset_active <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      reset_active <= (next_state != ST_IDLE);
      tcnt  <= (next_state != state) ? 8'h00 : tcnt + 8'h01;
      if (accept) begin
        step        <= 2'd0;
        cur_mask    <= grp_mask;
        cur_addr    <= grp_addr;
        cur_count   <= group;
        cur_release <= is_rel;
      end else if (state == ST_GAP && gap_end) begin
        step <= step + 2'd1;
      end
    end
  end

  // driver controls stand during the strobe; driver holds level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      driver_ctrl <= '0;
    end else if (ce) begin
      driver_ctrl.strobe <= (next_state == ST_STROBE);
      if (state == ST_SETUP) begin
        driver_ctrl.count <= mirror_pkg::group_t'(cur_count);
        driver_ctrl.level <= wave_level(step, cur_release,
                                        type_short);
        driver_ctrl.addr  <= cur_addr;
      end
    end
  end

  // ==========================================================
  // serial port to the driver; second select kept idle
  serial_port u_sport (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .start   (sp_start),
    .tx_byte (pwdata[7:0]),
    .miso    (miso_s),
    .sel_n   (driver_port_select_n_a),
    .sck     (serial_port_clock),
    .mosi    (serial_port_data_in),
    .busy    (sp_busy),
    .rx_byte (sp_rx)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) driver_port_select_n_b <= 1'b1;
    else if (ce) driver_port_select_n_b <= 1'b1;
  end

  // ==========================================================
  // checks
  property p_strobe_width;
    @(posedge clk) disable iff (!rstn)
    ce && $rose(driver_ctrl.strobe) |=>
      ce [*1] ##0 driver_ctrl.strobe ##1 ce && !driver_ctrl.strobe;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe width wrong");

  property p_refuse;
    @(posedge clk) disable iff (!rstn)
    ce && req && is_direct && !all_loaded |=> refused && !reset_active;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("unloaded direct pulse not refused");

  property p_release_starts;
    @(posedge clk) disable iff (!rstn)
    ce && req && is_rel |=> reset_active;
  endproperty
  a_release_starts: assert property (p_release_starts)
    else $error("release pulse not started");

  property p_direct_starts;
    @(posedge clk) disable iff (!rstn)
    ce && req && is_direct && all_loaded |=> reset_active;
  endproperty
  a_direct_starts: assert property (p_direct_starts)
    else $error("loaded direct pulse not started");

  property p_busy_tracks;
    @(posedge clk) disable iff (!rstn)
    reset_active == (state != ST_IDLE);
  endproperty
  a_busy_tracks: assert property (p_busy_tracks)
    else $error("busy flag out of step");

  property p_align;
    @(posedge clk) disable iff (!rstn)
    driver_ctrl.strobe |->
      (driver_ctrl.count != mirror_pkg::GROUP_DUAL ||
       !driver_ctrl.addr[0]) &&
      (driver_ctrl.count != mirror_pkg::GROUP_QUAD ||
       driver_ctrl.addr[1:0] == 2'b00);
  endproperty
  a_align: assert property (p_align)
    else $error("group address misaligned");

  property p_first_level;
    @(posedge clk) disable iff (!rstn)
    ce && accept && is_rel |-> ##3 driver_ctrl.strobe &&
      driver_ctrl.level == mirror_pkg::LEVEL_RESET;
  endproperty
  a_first_level: assert property (p_first_level)
    else $error("release waveform starts at wrong level");

  property p_seq_bound;
    @(posedge clk) disable iff (!rstn)
    $rose(reset_active) |-> ##[6:60] !reset_active;
  endproperty
  a_seq_bound: assert property (p_seq_bound)
    else $error("pulse sequence length out of bounds");

  property p_apb_answer;
    @(posedge clk) disable iff (!rstn)
    ce && apb_take |=> pready && (pslverr == !$past(hit));
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("bus answer wrong");

  c_direct:  cover property (@(posedge clk) accept && is_direct);
  c_release: cover property (@(posedge clk) accept && is_rel);
  c_refuse:  cover property (@(posedge clk) refuse);
  c_loaded:  cover property (@(posedge clk) blk_end);
endmodule

/* tb/pulse_driver_model.sv */
// behavioural pulse driver and serial slave facing the controller
`timescale 1ns/1ps
module pulse_driver_model (
  input  wire mirror_pkg::driver_ctrl_t ctrl,
  input  wire logic                     sel_n,
  input  wire logic                     sck,
  input  wire logic                     sdi,
  output logic                          sdo,
  output logic [1:0]                    level,
  output int                            events
);
  initial level = 2'h0;
  initial events = 0;
  initial sdo = 1'b1;
  // ==========================================================
  // outputs latch the level on strobe rise; held until next event
  always @(posedge ctrl.strobe) begin
    level  <= ctrl.level;
    events <= events + 1;
  end
  // echo inverted bits from select fall on, so the first bit is ready
  // before the first rising sck; a released line flips its last value
  always @(negedge sck or sel_n) begin
    sdo <= sel_n ? ~sdo : ~sdi;
  end
endmodule

/* tb/tb_mirror_reset_ctrl.sv */
// self-checking bench for the mirror block pulse controller
`timescale 1ns/1ps
module tb_mirror_reset_ctrl;
  // ==========================================================
  // stimulus and observed signals
  logic                     clk = 1'b0;
  logic                     rstn = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [31:0]              pwdata = 32'h0000_0000;
  logic [31:0]              prdata, rd;
  logic                     pready, pslverr, rd_err;
  mirror_pkg::in_bus_t      bus_in_a = '0;
  mirror_pkg::in_bus_t      bus_in_b = '0;
  logic [3:0]               type_id = mirror_pkg::ARRAY_TYPE_SHORT;
  logic                     irq = 1'b0;
  logic [3:0]               block_select = 4'h0;
  mirror_pkg::cmd_t         block_command_mode = mirror_pkg::CMD_NONE;
  mirror_pkg::out_bus_t     array_bus_a, array_bus_b;
  mirror_pkg::driver_ctrl_t driver_ctrl;
  logic                     sel_n, sck, sdi, sdo, reset_active, sel_b;
  logic                     sel_seen = 1'b0;
  logic [1:0]               level;
  logic [3:0]               ga [4] = '{4'h7, 4'h6, 4'h4, 4'h0};
  int                       events, error_cnt = 0, n_tests = 0;
  always #50 clk = ~clk;
  always @(negedge sel_n) sel_seen = 1'b1;
  // short rows keep block loading quick
  mirror_reset_ctrl #(.ROW_WORDS(2)) i_dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_in_a(bus_in_a), .bus_in_b(bus_in_b),
    .block_select(block_select),
    .block_command_mode(block_command_mode),
    .array_type_id(type_id),
    .serial_port_data_out(sdo), .driver_irq(irq),
    .array_bus_a(array_bus_a), .array_bus_b(array_bus_b),
    .driver_ctrl(driver_ctrl),
    .driver_port_select_n_a(sel_n), .driver_port_select_n_b(sel_b),
    .serial_port_clock(sck), .serial_port_data_in(sdi),
    .reset_active(reset_active));
  pulse_driver_model i_drv (.ctrl(driver_ctrl), .sel_n(sel_n), .sck(sck),
    .sdi(sdi), .sdo(sdo), .level(level), .events(events));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples pready high; data taken there
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command held for exactly one cycle
  task automatic cmd(input mirror_pkg::cmd_t c, input logic [3:0] b);
    @(posedge clk);
    block_select <= b;
    block_command_mode <= c;
    @(posedge clk);
    block_command_mode <= mirror_pkg::CMD_NONE;
  endtask
  task automatic pulse(input mirror_pkg::cmd_t c, input logic [3:0] b,
                       input logic [6:0] exp, input logic [1:0] lvl,
                       input int ne);
    int n, e0;
    n = 0;
    e0 = events;
    cmd(c, b);
    while (driver_ctrl.strobe !== 1'b1 && ++n < 100) @(negedge clk);
    chk({reset_active, driver_ctrl.count, driver_ctrl.addr}, exp);
    while (reset_active !== 1'b0 && ++n < 200) @(negedge clk);
    chk(events - e0, ne);
    chk(level, lvl);
  endtask
  // data moves mid half-period so it is steady around each clock edge
  task automatic feed(input int n);
    repeat (n) begin
      bus_in_a.data <= bus_in_a.data + 16'h1357;
      bus_in_a.valid <= 1'b1;
      bus_in_b.data <= ~(bus_in_a.data + 16'h1357);
      bus_in_b.valid <= 1'b1;
      repeat (2) @(posedge clk);
      bus_in_a.clk <= ~bus_in_a.clk;
      bus_in_b.clk <= ~bus_in_b.clk;
      repeat (2) @(posedge clk);
    end
    bus_in_a.valid <= 1'b0;
    bus_in_b.valid <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(8'h10, 1'b0, 32'h0);
    chk(32'(rd_err), 32'h0000_0001);
    for (int g = 0; g < 4; g++) begin
      apb(mirror_pkg::OFF_CTRL, 1'b1, 32'(g));
      apb(mirror_pkg::OFF_CTRL, 1'b0, 32'h0);
      chk(rd, 32'(g));
    end
    $display("test registers done");
    apb(mirror_pkg::OFF_CTRL, 1'b1, 32'h0);
    cmd(mirror_pkg::CMD_DIRECT, 4'h5);
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0012);
    apb(mirror_pkg::OFF_STATUS, 1'b1, 32'h0000_0002);
    $display("test refused done");
    feed(96);
    repeat (4) @(posedge clk);
    chk(array_bus_a.data, bus_in_a.data);
    chk(array_bus_b.data, bus_in_b.data);
    apb(mirror_pkg::OFF_LOADED, 1'b0, 32'h0);
    chk(rd, 32'h0000_0020);
    // global direct pulse with one block loaded must be refused
    apb(mirror_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
    cmd(mirror_pkg::CMD_DIRECT, 4'h5);
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0012);
    apb(mirror_pkg::OFF_STATUS, 1'b1, 32'h0000_0002);
    apb(mirror_pkg::OFF_CTRL, 1'b1, 32'h0);
    pulse(mirror_pkg::CMD_DIRECT, 4'h5, 7'h45, 2'h0, 2);
    apb(mirror_pkg::OFF_LOADED, 1'b0, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test direct done");
    for (int g = 0; g < 4; g++) begin
      apb(mirror_pkg::OFF_CTRL, 1'b1, 32'(g));
      pulse(mirror_pkg::CMD_RELEASE, 4'h7, {1'b1, 2'(g), ga[g]}, 2'h1, 2);
    end
    $display("test release done");
    apb(mirror_pkg::OFF_SPORT, 1'b1, 32'h0000_00a5);
    repeat (100) @(posedge clk);
    apb(mirror_pkg::OFF_SPORT, 1'b0, 32'h0);
    chk(rd, 32'h0000_005a);
    chk(32'(sel_seen), 32'h0000_0001);
    chk(32'(sel_b), 32'h0000_0001);
    // driver interrupt is sticky until the status clear
    irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0018);
    apb(mirror_pkg::OFF_STATUS, 1'b1, 32'h0000_0002);
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0010);
    $display("test serial done");
    // second reset with another array type: long direct waveform
    type_id <= 4'h2;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    apb(mirror_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000_0020);
    feed(96);
    pulse(mirror_pkg::CMD_DIRECT, 4'h7, 7'h47, 2'h0, 3);
    $display("test long waveform done");
    finish_test;
  end
  // watchdog: whole run needs well under 10000 cycles
  initial begin
    #3_000_000;
    error_cnt++;
    finish_test;
  end
endmodule
